// file: pkg/tw_map.svh
// Register offsets, field positions and constants of the waveform block
`ifndef TW_MAP_SVH
`define TW_MAP_SVH
`define TW_OFS_CTRL_A 8'h24
`define TW_OFS_CTRL_B 8'h25
`define TW_OFS_COUNT 8'h26
`define TW_OFS_CMP_A 8'h27
`define TW_OFS_CMP_B 8'h28
`define TW_OFS_STATUS 8'h29
`define TW_OFS_MASK 8'h2A
`define TW_POS_CODE_A 6
`define TW_POS_CODE_B 4
`define TW_POS_HIGH_BIT 3
`define TW_FLAG_OVF 0
`define TW_FLAG_A 1
`define TW_FLAG_B 2
`define TW_RESET_BYTE 8'h00
`define TW_MAX 8'hFF
`define TW_BOTTOM 8'h00
`endif

// file: pkg/tw_pkg.sv
// Types shared by the waveform compare control block
package tw_pkg;
    typedef logic [7:0] tw_byte_t;
    typedef enum logic [2:0] {
        TW_NORMAL  = 3'h0,
        TW_PC_FF   = 3'h1,
        TW_CTC     = 3'h2,
        TW_FAST_FF = 3'h3,
        TW_RSV4    = 3'h4,
        TW_PC_A    = 3'h5,
        TW_RSV6    = 3'h6,
        TW_FAST_A  = 3'h7
    } tw_mode_t;
    typedef enum logic [1:0] {
        TW_OFF    = 2'h0,
        TW_TOGGLE = 2'h1,
        TW_CLEAR  = 2'h2,
        TW_SET    = 2'h3
    } tw_code_t;
    typedef struct packed {
        tw_code_t codeA;
        tw_code_t codeB;
        logic [1:0] lowBits;
        logic highBit;
        tw_byte_t count;
        logic countDown;
        tw_byte_t bufA;
        tw_byte_t bufB;
        tw_byte_t cmpA;
        tw_byte_t cmpB;
        logic outA;
        logic outB;
        logic [2:0] flags;
        logic [2:0] mask;
        logic blockMatch;
        tw_byte_t rdData;
    } tw_state_t;
endpackage

// file: src/tw_compare_out.sv
// Next value of one compare output from mode, code and counter events
`timescale 1ns/1ps
module tw_compare_out #(
    parameter bit IS_CHAN_A = 1'b1
) (
    input wire logic isFast,
    input wire logic isPc,
    input wire logic highBit,
    input wire tw_pkg::tw_code_t code,
    input wire logic matchEv,
    input wire logic bottomEv,
    input wire logic topEv,
    input wire logic cmpIsTop,
    input wire logic countingUp,
    input wire logic outCur,
    output logic outNxt
);
    import tw_pkg::*;

    always_comb begin
        outNxt = outCur;
        if (!isFast && !isPc) begin
            if (matchEv) begin
                unique case (code)
                    TW_OFF: outNxt = outCur;
                    TW_TOGGLE: outNxt = !outCur;
                    TW_CLEAR: outNxt = 1'b0;
                    TW_SET: outNxt = 1'b1;
                endcase
            end
        end else if (code == TW_TOGGLE) begin
            // Channel B treats this code as reserved and holds
            if (IS_CHAN_A && highBit && matchEv) begin
                outNxt = !outCur;
            end
        end else if (code[1]) begin
            if (isFast) begin
                if (bottomEv) begin
                    outNxt = !code[0];
                end else if (matchEv && !cmpIsTop) begin
                    outNxt = code[0];
                end
            end else if (cmpIsTop) begin
                if (topEv) begin
                    outNxt = !code[0];
                end
            end else if (matchEv) begin
                outNxt = countingUp ? code[0] : !code[0];
            end
        end
    end
endmodule

// file: src/tw_waveform_ctrl.sv
// Timer counter with two compare channels and waveform generation
`timescale 1ns/1ps
`include "tw_map.svh"
module tw_waveform_ctrl #(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire tw_pkg::tw_byte_t regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output tw_pkg::tw_byte_t regRdData,
    input wire logic timerTickEnable,
    output logic compareOutA,
    output logic compareOutB,
    output logic outOverrideA,
    output logic outOverrideB,
    output logic irq
);
    import tw_pkg::*;

    generate
        if (ADDR_W < 6) begin : g_addr_check
            $error("ADDR_W too narrow for the register map");
        end
    endgenerate

    function automatic logic isSel(
        input logic [ADDR_W-1:0] addr,
        input tw_byte_t ofs
    );
        isSel = (addr == ADDR_W'(ofs));
    endfunction

    tw_state_t s_r;
    tw_state_t s_nxt;
    tw_mode_t mode;
    logic isFast;
    logic isPc;
    logic isImmediate;
    logic topFromA;
    tw_byte_t top;
    logic atTop;
    logic cntRun;
    logic matchA;
    logic matchB;
    logic bottomEv;
    logic topEv;
    logic ovfEv;
    logic updateCmp;
    logic wrCount;
    logic [2:0] clrMask;
    logic [1:0] chCur;
    logic [1:0] chNxt;
    logic [1:0] chMatch;
    logic [1:0] chCmpTop;
    tw_code_t chCode [2];

    // Mode decode
    assign mode = tw_mode_t'({s_r.highBit, s_r.lowBits});
    assign isFast = (mode == TW_FAST_FF) || (mode == TW_FAST_A);
    assign isPc = (mode == TW_PC_FF) || (mode == TW_PC_A);
    assign isImmediate = !isFast && !isPc;
    assign topFromA = (mode == TW_CTC) || (mode == TW_PC_A)
        || (mode == TW_FAST_A);
    assign top = topFromA ? s_r.cmpA : `TW_MAX;
    assign atTop = (s_r.count == top);

    // Reserved modes leave the counter standing
    assign cntRun = timerTickEnable && (mode != TW_RSV4)
        && (mode != TW_RSV6);

    // Compare matches, blocked for one tick after a counter write
    assign matchA = cntRun && !s_r.blockMatch && (s_r.count == s_r.cmpA);
    assign matchB = cntRun && !s_r.blockMatch && (s_r.count == s_r.cmpB);

    assign bottomEv = isFast && cntRun && atTop;
    assign topEv = isPc && cntRun && atTop && !s_r.countDown;

    always_comb begin
        ovfEv = 1'b0;
        if (cntRun) begin
            unique case (mode)
                TW_NORMAL, TW_CTC, TW_FAST_FF:
                    ovfEv = (s_r.count == `TW_MAX);
                TW_FAST_A:
                    ovfEv = atTop;
                TW_PC_FF, TW_PC_A:
                    ovfEv = s_r.countDown
                        && (s_r.count == `TW_BOTTOM);
                default:
                    ovfEv = 1'b0;
            endcase
        end
    end

    assign updateCmp = isImmediate || topEv || bottomEv;
    assign wrCount = regWrEn && isSel(regAddr, `TW_OFS_COUNT);
    assign clrMask = (regWrEn && isSel(regAddr, `TW_OFS_STATUS))
        ? regWrData[2:0] : 3'h0;

    // Per-channel output stage
    assign chCode[0] = s_r.codeA;
    assign chCode[1] = s_r.codeB;
    assign chCur = {s_r.outB, s_r.outA};
    assign chMatch = {matchB, matchA};
    assign chCmpTop = {s_r.cmpB == top, s_r.cmpA == top};

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            tw_compare_out #(
                .IS_CHAN_A(ch == 0)
            ) u_out (
                .isFast(isFast),
                .isPc(isPc),
                .highBit(s_r.highBit),
                .code(chCode[ch]),
                .matchEv(chMatch[ch]),
                .bottomEv(bottomEv),
                .topEv(topEv),
                .cmpIsTop(chCmpTop[ch]),
                .countingUp(!s_r.countDown),
                .outCur(chCur[ch]),
                .outNxt(chNxt[ch])
            );
        end
    endgenerate

    always_comb begin
        s_nxt = s_r;
        s_nxt.outA = chNxt[0];
        s_nxt.outB = chNxt[1];

        // Counting sequence
        if (s_r.blockMatch && timerTickEnable) begin
            s_nxt.blockMatch = 1'b0;
        end
        if (cntRun) begin
            if (isPc) begin
                if (!s_r.countDown) begin
                    if (atTop) begin
                        s_nxt.countDown = 1'b1;
                        s_nxt.count = s_r.count - 8'h01;
                    end else begin
                        s_nxt.count = s_r.count + 8'h01;
                    end
                end else if (s_r.count == `TW_BOTTOM) begin
                    s_nxt.countDown = 1'b0;
                    s_nxt.count = s_r.count + 8'h01;
                end else begin
                    s_nxt.count = s_r.count - 8'h01;
                end
            end else if (atTop) begin
                s_nxt.count = `TW_BOTTOM;
            end else begin
                s_nxt.count = s_r.count + 8'h01;
            end
        end

        // Buffered compare values
        if (updateCmp) begin
            s_nxt.cmpA = s_r.bufA;
            s_nxt.cmpB = s_r.bufB;
        end

        // Sticky flags, a new event beats a clear
        s_nxt.flags = (s_r.flags & ~clrMask)
            | {matchB, matchA, ovfEv};

        // Register writes
        if (regWrEn) begin
            if (isSel(regAddr, `TW_OFS_CTRL_A)) begin
                s_nxt.codeA = tw_code_t'(regWrData[7:6]);
                s_nxt.codeB = tw_code_t'(regWrData[5:4]);
                s_nxt.lowBits = regWrData[1:0];
            end
            if (isSel(regAddr, `TW_OFS_CTRL_B)) begin
                s_nxt.highBit = regWrData[`TW_POS_HIGH_BIT];
            end
            if (wrCount) begin
                s_nxt.count = regWrData;
                s_nxt.blockMatch = 1'b1;
            end
            if (isSel(regAddr, `TW_OFS_CMP_A)) begin
                s_nxt.bufA = regWrData;
                if (isImmediate) begin
                    s_nxt.cmpA = regWrData;
                end
            end
            if (isSel(regAddr, `TW_OFS_CMP_B)) begin
                s_nxt.bufB = regWrData;
                if (isImmediate) begin
                    s_nxt.cmpB = regWrData;
                end
            end
            if (isSel(regAddr, `TW_OFS_MASK)) begin
                s_nxt.mask = regWrData[2:0];
            end
        end

        // Read data stand only in the cycle after the strobe
        s_nxt.rdData = `TW_RESET_BYTE;
        if (regRdEn) begin
            if (isSel(regAddr, `TW_OFS_CTRL_A)) begin
                s_nxt.rdData = {s_r.codeA, s_r.codeB, 2'b00,
                    s_r.lowBits};
            end else if (isSel(regAddr, `TW_OFS_CTRL_B)) begin
                s_nxt.rdData = {4'h0, s_r.highBit, 3'h0};
            end else if (isSel(regAddr, `TW_OFS_COUNT)) begin
                s_nxt.rdData = s_r.count;
            end else if (isSel(regAddr, `TW_OFS_CMP_A)) begin
                s_nxt.rdData = s_r.bufA;
            end else if (isSel(regAddr, `TW_OFS_CMP_B)) begin
                s_nxt.rdData = s_r.bufB;
            end else if (isSel(regAddr, `TW_OFS_STATUS)) begin
                s_nxt.rdData = {5'h00, s_r.flags};
            end else if (isSel(regAddr, `TW_OFS_MASK)) begin
                s_nxt.rdData = {5'h00, s_r.mask};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign regRdData = s_r.rdData;
    assign compareOutA = s_r.outA;
    assign compareOutB = s_r.outB;
    assign outOverrideA = (s_r.codeA != TW_OFF)
        && !(!isImmediate && s_r.codeA == TW_TOGGLE && !s_r.highBit);
    assign outOverrideB = (s_r.codeB != TW_OFF);
    assign irq = |(s_r.flags & s_r.mask);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    property p_rsv_read;
        regRdEn && isSel(regAddr, `TW_OFS_CTRL_A)
            |=> regRdData[3:2] == 2'b00;
    endproperty
    a_rsv_read: assert property (p_rsv_read)
        else $error("reserved control bits read nonzero");

    property p_override;
        regWrEn && isSel(regAddr, `TW_OFS_CTRL_A) && regWrData[7:6] != 2'h0
            && (regWrData[7] || !regWrData[0] || s_r.highBit)
            |=> outOverrideA;
    endproperty
    a_override: assert property (p_override)
        else $error("output A not handed to compare logic");

    property p_nonpwm_clear;
        isImmediate && s_r.codeA == TW_CLEAR && matchA |=> !compareOutA;
    endproperty
    a_nonpwm_clear: assert property (p_nonpwm_clear)
        else $error("non-PWM clear on match failed");

    property p_fast_bottom;
        isFast && s_r.codeA == TW_CLEAR && bottomEv |=> compareOutA;
    endproperty
    a_fast_bottom: assert property (p_fast_bottom)
        else $error("fast PWM output not set at bottom");

    property p_pc_up;
        isPc && s_r.codeA == TW_CLEAR && matchA && !s_r.countDown
            && s_r.cmpA != top |=> !compareOutA;
    endproperty
    a_pc_up: assert property (p_pc_up)
        else $error("phase PWM up match did not clear");

    property p_ctc_clear;
        mode == TW_CTC && matchA && !wrCount
            |=> s_r.count == `TW_BOTTOM && s_r.flags[`TW_FLAG_A];
    endproperty
    a_ctc_clear: assert property (p_ctc_clear)
        else $error("clear-on-match did not clear counter");

    property p_imm_update;
        mode == TW_NORMAL && regWrEn && isSel(regAddr, `TW_OFS_CMP_A)
            |=> s_r.cmpA == $past(regWrData);
    endproperty
    a_imm_update: assert property (p_imm_update)
        else $error("immediate compare update missing");

    property p_pc_ovf;
        isPc && cntRun && s_r.countDown && s_r.count == `TW_BOTTOM
            && !wrCount |=> s_r.flags[`TW_FLAG_OVF] && s_r.count == 8'h01;
    endproperty
    a_pc_ovf: assert property (p_pc_ovf)
        else $error("phase PWM overflow at bottom missing");

    property p_no_tick;
        !timerTickEnable && !wrCount |=> $stable(s_r.count);
    endproperty
    a_no_tick: assert property (p_no_tick)
        else $error("counter moved without a tick");

    property p_normal_wrap;
        mode == TW_NORMAL && cntRun && s_r.count == `TW_MAX && !wrCount
            |=> s_r.count == `TW_BOTTOM;
    endproperty
    a_normal_wrap: assert property (p_normal_wrap)
        else $error("normal mode did not wrap at 0xFF");

    property p_fast_top;
        isFast && s_r.codeB[1] && chCmpTop[1] && !bottomEv
            |=> $stable(compareOutB);
    endproperty
    a_fast_top: assert property (p_fast_top)
        else $error("fast PWM B acted on a match at TOP");

    property p_b_reserved;
        !isImmediate && s_r.codeB == TW_TOGGLE |=> $stable(compareOutB);
    endproperty
    a_b_reserved: assert property (p_b_reserved)
        else $error("reserved B code moved the output");

    property p_pc_top;
        isPc && s_r.codeB == TW_CLEAR && chCmpTop[1] && topEv
            |=> compareOutB;
    endproperty
    a_pc_top: assert property (p_pc_top)
        else $error("phase PWM B not set at TOP");

    c_fast_bottom: cover property (isFast && bottomEv);
    c_pc_top: cover property (topEv);
    c_ctc_match: cover property (mode == TW_CTC && matchA);
    c_irq: cover property (irq);
endmodule

// file: test/tb.sv
// Self-checking bench for the waveform compare control block
`timescale 1ns/1ps
`include "tw_map.svh"
module tb;
    import tw_pkg::*;
    logic ref_clk;
    logic rst_n;
    logic [7:0] regAddr;
    tw_byte_t regWrData;
    logic regWrEn;
    logic regRdEn;
    tw_byte_t regRdData;
    logic timerTickEnable;
    logic compareOutA;
    logic compareOutB;
    logic outOverrideA;
    logic outOverrideB;
    logic irq;
    int fails;
    int total_checks;
    tw_byte_t rv;
    logic keepA;

    tw_waveform_ctrl #(.ADDR_W(8)) DUT (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrEn(regWrEn),
        .regRdEn(regRdEn),
        .regRdData(regRdData),
        .timerTickEnable(timerTickEnable),
        .compareOutA(compareOutA),
        .compareOutB(compareOutB),
        .outOverrideA(outOverrideA),
        .outOverrideB(outOverrideB),
        .irq(irq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk8(input tw_byte_t got, input tw_byte_t exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input tw_byte_t d);
        @(posedge ref_clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output tw_byte_t d);
        @(posedge ref_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        #1 d = regRdData;
    endtask

    task automatic rdchk(input logic [7:0] a, input tw_byte_t exp);
        tw_byte_t d;
        rd(a, d);
        chk8(d, exp);
    endtask

    // Timer ticks on n consecutive edges, then settle
    task automatic tick(input int n);
        @(posedge ref_clk);
        timerTickEnable <= 1'b1;
        repeat (n) @(posedge ref_clk);
        timerTickEnable <= 1'b0;
        #1;
    endtask

    // Single ticks until the counter reads v, bounded
    task automatic tick_to(input tw_byte_t v);
        int n;
        n = 0;
        rd(`TW_OFS_COUNT, rv);
        while (rv !== v) begin
            if (n == 600) begin
                fails++;
                close_out();
            end
            tick(1);
            rd(`TW_OFS_COUNT, rv);
            n++;
        end
    endtask

    initial begin
        rst_n = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        timerTickEnable = 1'b0;
        fails = 0;
        total_checks = 0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        for (int i = 0; i < 7; i++) begin
            rdchk(8'h24 + 8'(i), 8'h00);
        end
        chk1(outOverrideA | outOverrideB | irq, 1'b0);
        rdchk(8'h30, 8'h00);
        wr(`TW_OFS_CTRL_A, 8'hFF);
        rdchk(`TW_OFS_CTRL_A, 8'hF3);
        chk1(outOverrideA & outOverrideB, 1'b1);
        wr(`TW_OFS_CTRL_A, 8'h00);
        chk1(outOverrideA | outOverrideB, 1'b0);
        wr(`TW_OFS_CTRL_A, 8'h41);
        chk1(outOverrideA, 1'b0);
        wr(`TW_OFS_CTRL_B, 8'hFF);
        chk1(outOverrideA, 1'b1);
        rdchk(`TW_OFS_CTRL_B, 8'h08);
        wr(`TW_OFS_CTRL_B, 8'h00);
        // Normal mode: A toggles, B sets, then both clear
        wr(`TW_OFS_CTRL_A, 8'h70);
        wr(`TW_OFS_CMP_A, 8'h02);
        wr(`TW_OFS_CMP_B, 8'h02);
        tick(2);
        chk1(compareOutA, 1'b0);
        tick(1);
        chk1(compareOutA, 1'b1);
        chk1(compareOutB, 1'b1);
        rdchk(`TW_OFS_STATUS, 8'h06);
        wr(`TW_OFS_CTRL_A, 8'hA0);
        tick_to(8'h02);
        chk1(compareOutA, 1'b1);
        tick(1);
        chk1(compareOutA, 1'b0);
        chk1(compareOutB, 1'b0);
        rdchk(`TW_OFS_STATUS, 8'h07);
        // Interrupt level follows flags and mask
        wr(`TW_OFS_MASK, 8'h01);
        chk1(irq, 1'b1);
        wr(`TW_OFS_MASK, 8'h00);
        chk1(irq, 1'b0);
        wr(`TW_OFS_MASK, 8'h07);
        rdchk(`TW_OFS_MASK, 8'h07);
        wr(`TW_OFS_STATUS, 8'h07);
        rdchk(`TW_OFS_STATUS, 8'h00);
        chk1(irq, 1'b0);
        // Clear-on-match: TOP from compare A
        wr(`TW_OFS_CTRL_A, 8'h02);
        wr(`TW_OFS_CMP_A, 8'h04);
        wr(`TW_OFS_COUNT, 8'h00);
        tick(4);
        rdchk(`TW_OFS_COUNT, 8'h04);
        tick(1);
        rdchk(`TW_OFS_COUNT, 8'h00);
        rdchk(`TW_OFS_STATUS, 8'h06);
        wr(`TW_OFS_STATUS, 8'h07);
        // Fast PWM, A non-inverting, B inverting, buffered compares
        wr(`TW_OFS_CTRL_A, 8'hB3);
        wr(`TW_OFS_CMP_A, 8'h10);
        wr(`TW_OFS_CMP_B, 8'h10);
        wr(`TW_OFS_COUNT, 8'h00);
        tick_to(8'hFF);
        tick(1);
        chk1(compareOutA, 1'b1);
        chk1(compareOutB, 1'b0);
        tick_to(8'h10);
        chk1(compareOutA, 1'b1);
        tick(1);
        chk1(compareOutA, 1'b0);
        chk1(compareOutB, 1'b1);
        // Phase-correct: up match then down match
        wr(`TW_OFS_CTRL_A, 8'hB1);
        wr(`TW_OFS_COUNT, 8'h00);
        tick_to(8'h10);
        tick(1);
        chk1(compareOutA, 1'b0);
        chk1(compareOutB, 1'b1);
        tick(20);
        tick_to(8'h10);
        chk1(compareOutA, 1'b0);
        tick(1);
        chk1(compareOutA, 1'b1);
        chk1(compareOutB, 1'b0);
        // Overflow only at bottom while counting down
        wr(`TW_OFS_STATUS, 8'h07);
        tick_to(8'h00);
        tick(1);
        rdchk(`TW_OFS_COUNT, 8'h01);
        rdchk(`TW_OFS_STATUS, 8'h01);
        // Mode 7: A toggles at TOP from compare A, counter clears
        wr(`TW_OFS_CTRL_B, 8'h08);
        wr(`TW_OFS_CTRL_A, 8'h73);
        wr(`TW_OFS_CMP_A, 8'h08);
        wr(`TW_OFS_COUNT, 8'h00);
        tick_to(8'h10);
        tick(1);
        rdchk(`TW_OFS_COUNT, 8'h00);
        keepA = compareOutA;
        wr(`TW_OFS_STATUS, 8'h07);
        tick_to(8'h08);
        chk1(compareOutA, keepA);
        tick(1);
        chk1(compareOutA, ~keepA);
        rdchk(`TW_OFS_COUNT, 8'h00);
        rdchk(`TW_OFS_STATUS, 8'h03);
        chk1(irq, 1'b1);
        // Reserved mode 4 holds the counter
        wr(`TW_OFS_CTRL_A, 8'h00);
        tick(3);
        rd(`TW_OFS_COUNT, rv);
        tick(5);
        rdchk(`TW_OFS_COUNT, rv);
        // Phase-correct, TOP from compare A, both compares at TOP
        wr(`TW_OFS_CMP_A, 8'h08);
        wr(`TW_OFS_CMP_B, 8'h08);
        wr(`TW_OFS_CTRL_A, 8'hA1);
        wr(`TW_OFS_COUNT, 8'h00);
        tick_to(8'h08);
        chk1(compareOutB, 1'b0);
        tick(1);
        chk1(compareOutB, 1'b1);
        rdchk(`TW_OFS_COUNT, 8'h07);
        // A toggles with high mode bit, B code 01 holds
        wr(`TW_OFS_CTRL_A, 8'h51);
        keepA = compareOutA;
        tick_to(8'h08);
        tick(1);
        chk1(compareOutA, ~keepA);
        chk1(compareOutB, 1'b1);
        close_out();
    end
endmodule
